// ---- inc/ssp_defines.vh ----
// constants shared by the scan signature and pattern test block
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define SSP_IR_W 8
`define SSP_SIG_W 18
`define SSP_BCR_W 3

// ----------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------
`define SSP_IR_CAPTURE 8'h81
`define SSP_IR_BYPASS 8'hff
`define SSP_IR_SAMPLE 8'h82
`define SSP_IR_RUN 8'h09
`define SSP_IR_READ 8'h0f
`define SSP_IR_BCR_SCAN 8'h05

// ----------------------------------------------------------------
// boundary control codes and reset value
// ----------------------------------------------------------------
`define SSP_BCR_SIG_RANDOM 3'h3
`define SSP_BCR_SIG_COUNT 3'h7
`define SSP_BCR_RESET 3'h0

// ----------------------------------------------------------------
// feedback tap of the 18-bit shift loop (bit 17 is the other tap)
// ----------------------------------------------------------------
`define SSP_LFSR_TAP 10

// ----------------------------------------------------------------
// controller state bit positions (one-hot)
// ----------------------------------------------------------------
`define SSP_ST_TLR 0
`define SSP_ST_RTI 1
`define SSP_ST_SEL_DR 2
`define SSP_ST_CAP_DR 3
`define SSP_ST_SHIFT_DR 4
`define SSP_ST_EXIT1_DR 5
`define SSP_ST_PAUSE_DR 6
`define SSP_ST_EXIT2_DR 7
`define SSP_ST_UPD_DR 8
`define SSP_ST_SEL_IR 9
`define SSP_ST_CAP_IR 10
`define SSP_ST_SHIFT_IR 11
`define SSP_ST_EXIT1_IR 12
`define SSP_ST_PAUSE_IR 13
`define SSP_ST_EXIT2_IR 14
`define SSP_ST_UPD_IR 15

`endif

// ---- design/ssp_tap.v ----
// test access port state machine, advanced on detected tck rising edges
`timescale 1ns/10ps
`include "ssp_defines.vh"

module ssp_tap (
    input wire sys_clk_in,
    input wire sys_rst_in,
    input wire tck_rise_in,
    input wire tms_in,
    output reg [15:0] state_out
);

    localparam [15:0] TLR = 16'h0001;
    localparam [15:0] RTI = 16'h0002;
    localparam [15:0] SEL_DR = 16'h0004;
    localparam [15:0] CAP_DR = 16'h0008;
    localparam [15:0] SHIFT_DR = 16'h0010;
    localparam [15:0] EXIT1_DR = 16'h0020;
    localparam [15:0] PAUSE_DR = 16'h0040;
    localparam [15:0] EXIT2_DR = 16'h0080;
    localparam [15:0] UPD_DR = 16'h0100;
    localparam [15:0] SEL_IR = 16'h0200;
    localparam [15:0] CAP_IR = 16'h0400;
    localparam [15:0] SHIFT_IR = 16'h0800;
    localparam [15:0] EXIT1_IR = 16'h1000;
    localparam [15:0] PAUSE_IR = 16'h2000;
    localparam [15:0] EXIT2_IR = 16'h4000;
    localparam [15:0] UPD_IR = 16'h8000;

    reg [15:0] next_state;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always @* begin
        case (state_out)
            TLR: next_state = tms_in ? TLR : RTI;
            RTI: next_state = tms_in ? SEL_DR : RTI;
            SEL_DR: next_state = tms_in ? SEL_IR : CAP_DR;
            CAP_DR: next_state = tms_in ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: next_state = tms_in ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: next_state = tms_in ? UPD_DR : PAUSE_DR;
            PAUSE_DR: next_state = tms_in ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: next_state = tms_in ? UPD_DR : SHIFT_DR;
            UPD_DR: next_state = tms_in ? SEL_DR : RTI;
            SEL_IR: next_state = tms_in ? TLR : CAP_IR;
            CAP_IR: next_state = tms_in ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: next_state = tms_in ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: next_state = tms_in ? UPD_IR : PAUSE_IR;
            PAUSE_IR: next_state = tms_in ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: next_state = tms_in ? UPD_IR : SHIFT_IR;
            UPD_IR: next_state = tms_in ? SEL_DR : RTI;
            default: next_state = TLR;
        endcase
    end

    // ----------------------------------------------------------------
    // state register, moves only on a tck rising edge
    // ----------------------------------------------------------------
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state_out <= TLR;
        end else if (tck_rise_in) begin
            state_out <= next_state;
        end
    end

endmodule

// ---- design/ssp_top.v ----
// boundary-scan test logic with signature, random and count pattern runs
`timescale 1ns/10ps
`include "ssp_defines.vh"

// Functional notes
// - in both combined modes, input cells fold inputs into 18-bit signature each rise
// - signature/random mode advances 18-bit random pattern in output cells each rise
// - signature/count mode increments 18-bit output count each rise
// - output pattern goes to shadow latches and pins on each tck fall
// - an all-zero random seed stays zero forever
// - all test work is tck-synchronous; tdi, tms, inputs sampled on rise
// - tdo and pattern outputs change only on tck fall
// - in shift states data enters on tdi and leaves on tdo
// - instruction register loads 10000001 on the rise leaving capture-ir
// - tdo enables on the fall entering shift; first bit shifts next rise
// - instruction register shifts one bit per rise in shift-ir onto tdo
// - all-ones instruction decodes as bypass once updated
// - tdo returns to high impedance on the fall in exit1-ir
// - active instruction takes shifted value on the fall in update-ir
// - runs execute only with run instruction active in run-test/idle
// - control code 011 selects signature/random, 111 selects signature/count
// - runs need both halves in one common direction, else bypass behaviour
module ssp_top #(
    parameter SIG_W = `SSP_SIG_W
) (
    input wire sys_clk_in,
    input wire sys_rst_in,
    input wire tck_in,
    input wire tms_in,
    input wire tdi_in,
    input wire [SIG_W-1:0] sample_data_in,
    input wire a_to_b_output_enable_1_n_in,
    input wire b_to_a_output_enable_1_n_in,
    input wire a_to_b_output_enable_2_n_in,
    input wire b_to_a_output_enable_2_n_in,
    output reg tdo_out,
    output reg tdo_oe_out,
    output reg [SIG_W-1:0] pattern_out,
    output reg pattern_oe_out
);

    // ----------------------------------------------------------------
    // synchronisers: every pin passes two flops before use
    // ----------------------------------------------------------------
    reg tck_m;
    reg tck_s;
    reg tck_d;
    reg tms_m;
    reg tms_s;
    reg tdi_m;
    reg tdi_s;
    reg [3:0] oe_m;
    reg [3:0] oe_s;
    reg [SIG_W-1:0] din_m;
    reg [SIG_W-1:0] din_s;

    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            // tck idles low; a cleared history gives no false edge after a short reset
            tck_m <= 1'b0;
            tck_s <= 1'b0;
            tck_d <= 1'b0;
            tms_m <= 1'b1;
            tms_s <= 1'b1;
            tdi_m <= 1'b0;
            tdi_s <= 1'b0;
            oe_m <= 4'hf;
            oe_s <= 4'hf;
            din_m <= {SIG_W{1'b0}};
            din_s <= {SIG_W{1'b0}};
        end else begin
            tck_m <= tck_in;
            tck_s <= tck_m;
            tck_d <= tck_s;
            tms_m <= tms_in;
            tms_s <= tms_m;
            tdi_m <= tdi_in;
            tdi_s <= tdi_m;
            oe_m <= {b_to_a_output_enable_2_n_in, a_to_b_output_enable_2_n_in,
                     b_to_a_output_enable_1_n_in, a_to_b_output_enable_1_n_in};
            oe_s <= oe_m;
            din_m <= sample_data_in;
            din_s <= din_m;
        end
    end

    // edges taken from the second and third stage, never the first
    // a tck phase shorter than one system clock may be missed; nothing flags it
    wire tck_rise = tck_s & ~tck_d;
    wire tck_fall = ~tck_s & tck_d;

    // ----------------------------------------------------------------
    // controller
    // ----------------------------------------------------------------
    wire [15:0] st;

    ssp_tap u_tap (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .tck_rise_in(tck_rise),
        .tms_in(tms_s),
        .state_out(st)
    );

    // ----------------------------------------------------------------
    // instruction and data registers
    // ----------------------------------------------------------------
    reg [`SSP_IR_W-1:0] ir_shift;
    reg [`SSP_IR_W-1:0] active_ir;
    reg bypass_bit;
    reg [`SSP_BCR_W-1:0] bcr_shift;
    reg [`SSP_BCR_W-1:0] boundary_control_register;
    // low half: input-mode cells, high half: output-mode cells
    reg [2*SIG_W-1:0] boundary_register;
    reg [SIG_W-1:0] shadow;

    // both halves one direction each, and the same direction
    wire dir_ok = (oe_s[0] != oe_s[1]) && (oe_s[2] != oe_s[3]) && (oe_s[0] == oe_s[2]);
    wire is_run = (active_ir == `SSP_IR_RUN) && dir_ok;
    wire mode_rand = (boundary_control_register == `SSP_BCR_SIG_RANDOM);
    wire mode_count = (boundary_control_register == `SSP_BCR_SIG_COUNT);
    wire run_act = is_run && st[`SSP_ST_RTI] && (mode_rand || mode_count);
    wire sel_bsr = (active_ir == `SSP_IR_SAMPLE) || (active_ir == `SSP_IR_READ);
    wire sel_bcr = (active_ir == `SSP_IR_BCR_SCAN);

    // shift loop with feedback from bit 17 and one tap; zero maps to zero
    function [SIG_W-1:0] lfsr_step;
        input [SIG_W-1:0] v;
        begin
            lfsr_step = {v[SIG_W-2:0], v[SIG_W-1] ^ v[`SSP_LFSR_TAP]};
        end
    endfunction

    wire [SIG_W-1:0] sig_cur = boundary_register[SIG_W-1:0];
    wire [SIG_W-1:0] pat_cur = boundary_register[2*SIG_W-1:SIG_W];
    wire [SIG_W-1:0] sig_next = lfsr_step(sig_cur) ^ din_s;
    wire [SIG_W-1:0] pat_rand = lfsr_step(pat_cur);
    wire [SIG_W-1:0] pat_count = pat_cur + {{(SIG_W-1){1'b0}}, 1'b1};

    // ----------------------------------------------------------------
    // rising edge work: capture, shift, runs
    // ----------------------------------------------------------------
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            ir_shift <= `SSP_IR_CAPTURE;
            bypass_bit <= 1'b0;
            bcr_shift <= `SSP_BCR_RESET;
            boundary_register <= {(2*SIG_W){1'b0}};
        end else if (tck_rise) begin
            if (st[`SSP_ST_CAP_IR]) begin
                ir_shift <= `SSP_IR_CAPTURE;
            end else if (st[`SSP_ST_SHIFT_IR]) begin
                ir_shift <= {tdi_s, ir_shift[`SSP_IR_W-1:1]};
            end
            if (st[`SSP_ST_CAP_DR]) begin
                bypass_bit <= 1'b0;
                if (active_ir == `SSP_IR_SAMPLE) begin
                    boundary_register <= {shadow, din_s};
                end
            end else if (st[`SSP_ST_SHIFT_DR]) begin
                // first bit moves on the rise after the shift state is entered
                if (sel_bsr) begin
                    boundary_register <= {tdi_s, boundary_register[2*SIG_W-1:1]};
                end else if (sel_bcr) begin
                    bcr_shift <= {tdi_s, bcr_shift[`SSP_BCR_W-1:1]};
                end else begin
                    bypass_bit <= tdi_s;
                end
            end else if (run_act) begin
                // a cut frame freezes the cells: nothing steps without a detected rise
                boundary_register <= {mode_rand ? pat_rand : pat_count, sig_next};
            end
        end
    end

    // ----------------------------------------------------------------
    // falling edge work: updates, tdo, pins
    // ----------------------------------------------------------------
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            active_ir <= `SSP_IR_BYPASS;
            boundary_control_register <= `SSP_BCR_RESET;
            shadow <= {SIG_W{1'b0}};
            tdo_out <= 1'b0;
            tdo_oe_out <= 1'b0;
            pattern_out <= {SIG_W{1'b0}};
            pattern_oe_out <= 1'b0;
        end else if (tck_fall) begin
            if (st[`SSP_ST_TLR]) begin
                // reset state drops any run even while tck keeps toggling
                active_ir <= `SSP_IR_BYPASS;
                boundary_control_register <= `SSP_BCR_RESET;
            end else if (st[`SSP_ST_UPD_IR]) begin
                active_ir <= ir_shift;
            end else if (st[`SSP_ST_UPD_DR]) begin
                if (sel_bcr) begin
                    boundary_control_register <= bcr_shift;
                end else if (active_ir == `SSP_IR_SAMPLE) begin
                    shadow <= pat_cur;
                end
            end else if (run_act) begin
                shadow <= pat_cur;
            end
            // enabled while in a shift state, dropped in exit1
            tdo_oe_out <= st[`SSP_ST_SHIFT_IR] | st[`SSP_ST_SHIFT_DR];
            if (st[`SSP_ST_SHIFT_IR]) begin
                tdo_out <= ir_shift[0];
            end else if (st[`SSP_ST_SHIFT_DR]) begin
                tdo_out <= sel_bsr ? boundary_register[0] :
                           (sel_bcr ? bcr_shift[0] : bypass_bit);
            end
            // pins follow the shadow one fall later than the shadow latch, except in a run, where pins and shadow both take pat_cur on the same fall
            pattern_out <= run_act ? pat_cur : shadow;
            pattern_oe_out <= is_run;
        end
    end

endmodule

// ---- test/ssp_top_asserts.sv ----
// concurrent checks on the ports of the scan signature and pattern block
`timescale 1ns/10ps
`include "ssp_defines.vh"
module ssp_checker #(
    parameter SIG_W = 18
) (
    input wire sys_clk_in,
    input wire sys_rst_in,
    input wire tck_in,
    input wire tms_in,
    input wire tdi_in,
    input wire [SIG_W-1:0] sample_data_in,
    input wire a_to_b_output_enable_1_n_in,
    input wire b_to_a_output_enable_1_n_in,
    input wire a_to_b_output_enable_2_n_in,
    input wire b_to_a_output_enable_2_n_in,
    input wire tdo_out,
    input wire tdo_oe_out,
    input wire [SIG_W-1:0] pattern_out,
    input wire pattern_oe_out
);
    // a short tck history stands in for the design's edge finder; deep enough for its lag
    reg [6:0] hist = 7'h00;
    wire fell = |(hist[6:1] & ~hist[5:0]);
    wire quiet = (hist == 7'h00) || (hist == 7'h7f);
    wire dir_ok = (a_to_b_output_enable_1_n_in != b_to_a_output_enable_1_n_in)
        && (a_to_b_output_enable_2_n_in != b_to_a_output_enable_2_n_in)
        && (a_to_b_output_enable_1_n_in == a_to_b_output_enable_2_n_in);
    function [SIG_W-1:0] step(input [SIG_W-1:0] v);
        step = {v[SIG_W-2:0], v[SIG_W-1] ^ v[`SSP_LFSR_TAP]};
    endfunction
    always @(posedge sys_clk_in) begin
        hist <= {hist[5:0], tck_in};
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_TDO_ON_FALL: assert property ($changed(tdo_out) |-> fell)
        else $error("tdo moved away from a tck fall");
    AST_TDO_OE_ON_FALL: assert property ($changed(tdo_oe_out) |-> fell)
        else $error("tdo enable moved away from a tck fall");
    AST_PATTERN_ON_FALL: assert property ($changed(pattern_out) |-> fell)
        else $error("pattern moved away from a tck fall");
    AST_RUN_NEEDS_DIR: assert property ($rose(pattern_oe_out) |-> dir_ok)
        else $error("pattern drive began with mixed directions");
    AST_RESET_CLEARS: assert property (disable iff (1'b0) sys_rst_in |=>
        !tdo_oe_out && !pattern_oe_out && pattern_out == '0)
        else $error("outputs not cleared by reset");
    AST_PATTERN_STEP: assert property (pattern_oe_out && $past(pattern_oe_out)
        && $changed(pattern_out) |-> pattern_out == $past(pattern_out) + 1'b1
        || pattern_out == step($past(pattern_out)))
        else $error("pattern moved by other than one step");
    AST_ZERO_STAYS: assert property ((pattern_oe_out && $past(pattern_oe_out)
        && $changed(pattern_out) && $past(pattern_out) == '0) |-> pattern_out == 1)
        else $error("zero pattern left other than by counting");
    AST_QUIET_NO_TCK: assert property (quiet |-> $stable(tdo_out) && $stable(tdo_oe_out)
        && $stable(pattern_out))
        else $error("outputs moved without tck activity");
    cover property ($rose(tdo_oe_out));
    cover property ($rose(pattern_oe_out));
    cover property (pattern_oe_out && $changed(pattern_out));
endmodule
bind ssp_top ssp_checker #(.SIG_W(SIG_W)) i_chk (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .tck_in(tck_in), .tms_in(tms_in),
    .tdi_in(tdi_in), .sample_data_in(sample_data_in),
    .a_to_b_output_enable_1_n_in(a_to_b_output_enable_1_n_in),
    .b_to_a_output_enable_1_n_in(b_to_a_output_enable_1_n_in),
    .a_to_b_output_enable_2_n_in(a_to_b_output_enable_2_n_in),
    .b_to_a_output_enable_2_n_in(b_to_a_output_enable_2_n_in), .tdo_out(tdo_out),
    .tdo_oe_out(tdo_oe_out), .pattern_out(pattern_out), .pattern_oe_out(pattern_oe_out)
);

// ---- test/ssp_tap_master.sv ----
// test-port master model that clocks tck and drives tms and tdi
`timescale 1ns/10ps
module ssp_tap_master (
    input wire tdo_in,
    input wire tdo_oe_in,
    output reg tck_out,
    output reg tms_out,
    output reg tdi_out
);
    reg last = 1'b0;
    // tck rests low between frames; tms starts high so the device sits in reset
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // tms and tdi move just after the fall; tdo is read late in the high phase
    task bit_cycle(input tms, input tdi, output tdo, output oe);
        tms_out = tms;
        tdi_out = tdi;
        #400 tck_out = 1'b1;
        #300 oe = tdo_oe_in;
        tdo = oe ? tdo_in : ~last; // a released line shows no stale value
        last = tdo;
        #100 tck_out = 1'b0;
    endtask
endmodule

// ---- test/test_scan_signature_pattern_test.sv ----
// self-checking bench for the scan signature and pattern block
`timescale 1ns/10ps
`include "ssp_defines.vh"
`define CHK(g, e) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("ERROR %0t got %h want %h", $time, g, e); \
    end \
end
module test_scan_signature_pattern_test;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [17:0] sample_data = 18'h2d3c1;
    logic [3:0] dir_n = 4'b1010;
    logic tdo_bit;
    logic oe_bit;
    logic [35:0] q;
    int num_errors = 0;
    int cmp_count = 0;
    wire tck, tms, tdi, tdo, tdo_oe, pattern_oe;
    wire [17:0] pattern;
    ssp_top i_dut (
        .sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
        .sample_data_in(sample_data), .a_to_b_output_enable_1_n_in(dir_n[0]),
        .b_to_a_output_enable_1_n_in(dir_n[1]), .a_to_b_output_enable_2_n_in(dir_n[2]),
        .b_to_a_output_enable_2_n_in(dir_n[3]), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
        .pattern_out(pattern), .pattern_oe_out(pattern_oe)
    );
    ssp_tap_master i_mst (
        .tdo_in(tdo), .tdo_oe_in(tdo_oe), .tck_out(tck), .tms_out(tms), .tdi_out(tdi)
    );
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    function automatic [17:0] step(input [17:0] v);
        step = {v[16:0], v[17] ^ v[`SSP_LFSR_TAP]};
    endfunction
    task wrap_up;
        if (num_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // controller walks and scans; each scan starts and ends in run-test/idle
    // ----------------------------------------------------------------
    task walk(input [7:0] tms_bits, input int n);
        for (int i = 0; i < n; i++) begin
            i_mst.bit_cycle(tms_bits[i], 1'b0, tdo_bit, oe_bit);
        end
    endtask
    task shift(input [35:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            i_mst.bit_cycle(i == n - 1, d[i], q[i], oe_bit);
            `CHK(oe_bit, 1'b1)
        end
        i_mst.bit_cycle(1'b1, 1'b0, tdo_bit, oe_bit);
        `CHK(oe_bit, 1'b0)
        i_mst.bit_cycle(1'b0, 1'b0, tdo_bit, oe_bit);
    endtask
    task ir_scan(input [7:0] code);
        walk(8'h03, 4);
        shift({28'h0, code}, 8);
        `CHK(q[7:0], `SSP_IR_CAPTURE)
    endtask
    task dr_scan(input [35:0] d, input int n);
        walk(8'h01, 3);
        shift(d, n);
    endtask
    // the rise that leaves idle still steps the cells, so readback is one step on
    task run_mode(input [2:0] code, input [35:0] seed, input int k, input [3:0] dir, input ok);
        logic [17:0] pat;
        logic [17:0] sig;
        pat = seed[35:18];
        sig = seed[17:0];
        ir_scan(`SSP_IR_BCR_SCAN);
        dr_scan({33'h0, code}, 3);
        ir_scan(`SSP_IR_SAMPLE);
        dr_scan(seed, 36);
        @(negedge sys_clk) dir_n = dir;
        ir_scan(`SSP_IR_RUN);
        walk(8'h00, k);
        #1000;
        `CHK(pattern_oe, ok)
        for (int j = 0; j <= k && ok; j++) begin
            if (j == k) `CHK(pattern, pat)
            pat = (code == `SSP_BCR_SIG_COUNT) ? pat + 18'h1 : step(pat);
            sig = step(sig) ^ sample_data;
        end
        ir_scan(`SSP_IR_READ);
        dr_scan(36'h0, 36);
        `CHK(q[35:18], pat)
        `CHK(q[17:0], sig)
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_bypass;
        `CHK(tdo_oe, 1'b0)
        walk(8'h00, 1);
        ir_scan(`SSP_IR_READ);
        ir_scan(`SSP_IR_BYPASS);
        dr_scan(36'h5, 3);
        `CHK(q[2:0], 3'b010)
    endtask
    task t_random;
        run_mode(`SSP_BCR_SIG_RANDOM, {18'h2a5c3, 18'h1f00f}, 5, 4'b1010, 1'b1);
    endtask
    task t_count_wrap;
        run_mode(`SSP_BCR_SIG_COUNT, {18'h3fffe, 18'h00001}, 3, 4'b0101, 1'b1);
    endtask
    task t_zero_seed;
        run_mode(`SSP_BCR_SIG_RANDOM, 36'h0, 4, 4'b1010, 1'b1);
    endtask
    task t_bad_dir;
        run_mode(`SSP_BCR_SIG_COUNT, {18'h00abc, 18'h00123}, 3, 4'b0110, 1'b0);
    endtask
    initial begin
        #3000000;
        num_errors++;
        wrap_up;
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk) sys_rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        t_bypass;
        t_random;
        t_count_wrap;
        t_zero_seed;
        t_bad_dir;
        wrap_up;
    end
endmodule
